// ---- core/trf_pkg.sv ----
// package for the touch report block: register map, fields, timing
// assumes a 40 MHz core clock and byte-wide register access
package trf_pkg;
   localparam logic [7:0] TRF_QUEUE_ADDR   = 8'h00;
   localparam logic [7:0] TRF_FAULT_ADDR   = 8'h01;
   localparam logic [7:0] TRF_LIVE_ADDR    = 8'h02;
   localparam int         TRF_MORE_BIT     = 7;
   localparam int         TRF_EMPTY_BIT    = 6;
   localparam int         TRF_OVF_BIT      = 5;
   localparam int         TRF_PRESS_BIT    = 4;
   localparam int         TRF_TOUCH_BIT    = 4;
   localparam int         TRF_RATE_HI      = 7;
   localparam int         TRF_RATE_LO      = 5;
   localparam int         TRF_IRQ_EN_BIT   = 1;
   localparam int         TRF_RUN_BIT      = 0;
   localparam int         TRF_QUEUE_DEPTH  = 30;
   localparam int         TRF_FIFO_DEPTH   = 16;
   localparam logic [1:0] TRF_FAULT_NONE   = 2'h0;
   localparam logic [1:0] TRF_FAULT_GND    = 2'h1;
   localparam logic [1:0] TRF_FAULT_SUP    = 2'h2;
   localparam logic [7:0] TRF_RESET_BYTE   = 8'h00;
   localparam int         TRF_CLK_HZ       = 40000000;
   localparam int         TRF_UNIT_MS      = 4;
   localparam int         TRF_PERIOD_OFS   = 5;
   localparam int         TRF_DUTY_DIV     = 8;
   localparam int         TRF_CYC_PER_MS   = TRF_CLK_HZ / 1000;

   typedef struct packed {
      logic       press;
      logic [3:0] position;
   } trf_event_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       rd;
      logic       wr;
   } trf_req_s;
endpackage

// ---- core/trf_fifo.sv ----
// parameterised valid/ready fifo held in flip-flops
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module trf_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             flush_in,
   // write side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // read side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out,
   output logic      [5:0]       count_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [5:0]       count;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready_out  = (count < 6'(DEPTH));
   assign out_valid_out = (count != 6'h00);
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;
   assign out_data_out  = mem[rd_ptr];
   assign count_out     = count;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= 6'h00;
      end else if (flush_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= 6'h00;
      end else begin
         if (push) begin
            wr_ptr <= bump(wr_ptr);
         end
         if (pop) begin
            rd_ptr <= bump(rd_ptr);
         end
         count <= count + 6'(push) - 6'(pop);
      end
   end
endmodule

// ---- core/trf_report.sv ----
// touch report block: live status, event queue, fault code, interrupt pin
// assumes a register port already decoded from the serial slave, synchronous
// event strobes from the sensing logic, and an external pull-up on the pin
`timescale 1ns/1ps
// Summary of operation
// - live status bit 4 reads 1 while touched, 0 otherwise
// - live bits 3:0 give touched electrode code 0 to 7
// - queue holds 30 events; an event arriving while full is dropped
// - each queue read removes the oldest entry
// - any queue write empties it; reading the last entry also empties it
// - bit 7 shows entries remain after the current read
// - bit 6 shows queue holds no entries
// - bit 5 set once an event was dropped
// - bit 4 is 1 for touch, 0 for release
// - bits 3:0 give electrode of shown entry, 0 to 7
// - a recorded fault stops electrode scanning until cleared
// - with several faults only the first detected is kept
// - fault code 00 none, 01 short to ground, 10 short to supply
// - fault write clears only in stop mode, ignored while running
// - data interrupt fires when empty flag goes from 1 to 0
// - data interrupt released by queue access, rearmed only after empty
// - fault interrupt fires on zero to nonzero, released by fault write in stop mode
// - interrupt enable low ignores all sources, pin never latches
// - spacing (period+5)*rate*4 ms, duty-cycled variant takes next multiple of 8 above period+5
// - early sources wait for spacing to pass, else latch at once
// - interrupt pin active low, open drain, latching
// - rate factor bits 7:5 of configuration, codes 0..7 give 1..8
// - configuration bit 0 selects run or stop mode
module trf_report
   import trf_pkg::*;
(
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       reset_n_in,
   // register access port
   input  wire trf_req_s   req_in,
   output logic [7:0]      rdata_out,
   // configuration from the configuration register
   input  wire logic [7:0] config_in,
   input  wire logic [7:0] master_period_setting_in,
   input  wire logic       duty_cycled_run_mode_in,
   // sensing side
   input  wire logic       touch_active_flag_in,
   input  wire logic [3:0] live_position_in,
   input  wire logic       event_valid_in,
   input  wire trf_event_s event_in,
   input  wire logic       short_gnd_in,
   input  wire logic       short_sup_in,
   output logic            scan_allow_out,
   // interrupt pin, open drain
   output logic            irq_n_out,
   output logic            irq_n_oe_out
);
   localparam int EW = $bits(trf_event_s);
   // one spare slot so the tail store is never what refuses an event;
   // refusal comes only from the 30-entry cap
   localparam int TAIL_DEPTH = TRF_QUEUE_DEPTH - TRF_FIFO_DEPTH + 1;

   logic [1:0]  fault_code;
   logic        ovf;
   logic        data_pend;
   logic        data_armed;
   logic        fault_pend;
   logic        irq_latched;
   logic [31:0] space_cnt;
   logic        empty_q;
   logic [31:0] next_space;

   logic        rd_queue;
   logic        wr_queue;
   logic        wr_fault;
   logic        run_mode;
   logic        irq_en;
   logic [3:0]  rate_factor;
   logic        queue_empty_flag;
   logic        more_entries_flag;
   logic        ovf_push;
   logic        q_full;
   logic [5:0]  f_count;
   logic        f_in_ready;
   logic        f_out_valid;
   logic [EW-1:0] f_out_data;
   trf_event_s  head;
   logic [5:0]  total;
   logic        t_in_ready;
   logic        t_out_valid;
   logic [EW-1:0] t_out_data;
   logic [5:0]  t_count;
   logic        h_in_valid;
   logic [EW-1:0] h_in_data;
   logic        move_up;
   logic        take_head;
   logic        take_tail;

   assign rd_queue = req_in.rd && (req_in.addr == TRF_QUEUE_ADDR);
   assign wr_queue = req_in.wr && (req_in.addr == TRF_QUEUE_ADDR);
   assign wr_fault = req_in.wr && (req_in.addr == TRF_FAULT_ADDR);
   assign run_mode = config_in[TRF_RUN_BIT];
   assign irq_en   = config_in[TRF_IRQ_EN_BIT];
   assign rate_factor = {1'b0, config_in[TRF_RATE_HI:TRF_RATE_LO]}
                        + 4'h1;

   // the head fifo always holds the oldest entries; the tail store only
   // fills once the head is full and refills it one entry per cycle, so
   // the head never runs dry while the tail still holds entries
   assign total      = f_count + t_count;
   assign q_full     = (total >= 6'(TRF_QUEUE_DEPTH));
   assign move_up    = t_out_valid && f_in_ready;
   assign take_head  = event_valid_in && !q_full && !t_out_valid
                       && f_in_ready;
   assign take_tail  = event_valid_in && !q_full && !take_head;
   assign h_in_valid = move_up || take_head;
   assign h_in_data  = move_up ? t_out_data : event_in;
   assign ovf_push   = event_valid_in && !take_head
                       && !(take_tail && t_in_ready);

   trf_fifo #(
      .WIDTH (EW),
      .DEPTH (TRF_FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .reset_n_in    (reset_n_in),
      .flush_in      (wr_queue),
      .in_valid_in   (h_in_valid),
      .in_ready_out  (f_in_ready),
      .in_data_in    (h_in_data),
      .out_valid_out (f_out_valid),
      .out_ready_in  (rd_queue),
      .out_data_out  (f_out_data),
      .count_out     (f_count)
   );

   trf_fifo #(
      .WIDTH (EW),
      .DEPTH (TAIL_DEPTH)
   ) u_tail (
      .clk_in        (clk_in),
      .reset_n_in    (reset_n_in),
      .flush_in      (wr_queue),
      .in_valid_in   (take_tail),
      .in_ready_out  (t_in_ready),
      .in_data_in    (event_in),
      .out_valid_out (t_out_valid),
      .out_ready_in  (move_up),
      .out_data_out  (t_out_data),
      .count_out     (t_count)
   );

   assign head              = trf_event_s'(f_out_data);
   assign queue_empty_flag  = (total == 6'h00);
   assign more_entries_flag = (total > 6'h01);

   // overflow sticks until the queue drains or is flushed
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ovf <= 1'b0;
      end else if (ovf_push) begin
         ovf <= 1'b1;
      end else if (wr_queue || (rd_queue && total == 6'h01)) begin
         ovf <= 1'b0;
      end
   end

   always_comb begin
      rdata_out = TRF_RESET_BYTE;
      case (req_in.addr)
         TRF_QUEUE_ADDR: begin
            rdata_out[TRF_MORE_BIT]  = more_entries_flag;
            rdata_out[TRF_EMPTY_BIT] = queue_empty_flag;
            rdata_out[TRF_OVF_BIT]   = ovf;
            if (f_out_valid) begin
               rdata_out[TRF_PRESS_BIT] = head.press;
               rdata_out[3:0]           = head.position;
            end
         end
         TRF_FAULT_ADDR: rdata_out[1:0] = fault_code;
         TRF_LIVE_ADDR: begin
            rdata_out[TRF_TOUCH_BIT] = touch_active_flag_in;
            rdata_out[3:0]           = live_position_in;
         end
         default: rdata_out = TRF_RESET_BYTE;
      endcase
   end

   // fault: first detected wins, ground checked first in the scan
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         fault_code <= TRF_FAULT_NONE;
      end else if (fault_code == TRF_FAULT_NONE && run_mode) begin
         if (short_gnd_in) begin
            fault_code <= TRF_FAULT_GND;
         end else if (short_sup_in) begin
            fault_code <= TRF_FAULT_SUP;
         end
      end else if (wr_fault && !run_mode) begin
         fault_code <= TRF_FAULT_NONE;
      end
   end

   assign scan_allow_out = run_mode && (fault_code == TRF_FAULT_NONE);

   // source pending flags; set wins over release in the same cycle
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         empty_q    <= 1'b1;
         data_armed <= 1'b1;
         data_pend  <= 1'b0;
         fault_pend <= 1'b0;
      end else begin
         empty_q <= queue_empty_flag;
         if (queue_empty_flag) begin
            data_armed <= 1'b1;
         end else if (empty_q) begin
            data_armed <= 1'b0;
         end
         if (!irq_en) begin
            data_pend <= 1'b0;
         end else if (empty_q && !queue_empty_flag && data_armed) begin
            data_pend <= 1'b1;
         end else if (rd_queue || wr_queue) begin
            data_pend <= 1'b0;
         end
         if (!irq_en) begin
            fault_pend <= 1'b0;
         end else if (fault_code == TRF_FAULT_NONE && run_mode
                      && (short_gnd_in || short_sup_in)) begin
            fault_pend <= 1'b1;
         end else if (wr_fault && !run_mode) begin
            fault_pend <= 1'b0;
         end
      end
   end

   // spacing in cycles; computed wide so no product overflows
   always_comb begin
      logic [31:0] base;
      base = 32'(master_period_setting_in) + 32'(TRF_PERIOD_OFS);
      if (duty_cycled_run_mode_in) begin
         base = (base / 32'(TRF_DUTY_DIV) + 32'h1) * 32'(TRF_DUTY_DIV);
      end
      next_space = base * 32'(rate_factor) * 32'(TRF_UNIT_MS)
                   * 32'(TRF_CYC_PER_MS);
   end

   // latch holds off until spacing since the previous latch has passed
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_latched <= 1'b0;
         space_cnt   <= 32'h0;
      end else begin
         if (space_cnt != 32'h0) begin
            space_cnt <= space_cnt - 32'h1;
         end
         if (!irq_en) begin
            irq_latched <= 1'b0;
         end else if (!data_pend && !fault_pend) begin
            irq_latched <= 1'b0;
         end else if (!irq_latched && space_cnt == 32'h0) begin
            irq_latched <= 1'b1;
            space_cnt   <= next_space;
         end
      end
   end

   assign irq_n_out    = 1'b0;
   assign irq_n_oe_out = irq_latched;
endmodule

// ---- tb/trf_report_properties.sv ----
// assertion checker for trf_report, bound to every instance
// assumes reads are sampled in the cycle of the request
`timescale 1ns/1ps
module trf_report_properties
   import trf_pkg::*;
(
   // clock and reset
   input wire logic       clk_in,
   input wire logic       reset_n_in,
   // every other port of the block
   input wire trf_req_s   req_in,
   input wire logic [7:0] rdata_out,
   input wire logic [7:0] config_in,
   input wire logic [7:0] master_period_setting_in,
   input wire logic       duty_cycled_run_mode_in,
   input wire logic       touch_active_flag_in,
   input wire logic [3:0] live_position_in,
   input wire logic       event_valid_in,
   input wire trf_event_s event_in,
   input wire logic       short_gnd_in,
   input wire logic       short_sup_in,
   input wire logic       scan_allow_out,
   input wire logic       irq_n_out,
   input wire logic       irq_n_oe_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   wire logic q_rd = req_in.rd && req_in.addr == TRF_QUEUE_ADDR;
   wire logic q_wr = req_in.wr && req_in.addr == TRF_QUEUE_ADDR;
   wire logic f_sel = req_in.addr == TRF_FAULT_ADDR;
   sequence s_last_pop;
      q_rd && rdata_out[7:6] == 2'b00 && !event_valid_in;
   endsequence
   sequence s_flush;
      q_wr && !event_valid_in;
   endsequence
   property p_live;
      req_in.addr == TRF_LIVE_ADDR |->
         rdata_out == {3'h0, touch_active_flag_in, live_position_in};
   endproperty
   a_live: assert property (p_live) else $error("live byte");
   property p_pop;
      s_last_pop ##1 req_in.addr == TRF_QUEUE_ADDR |-> rdata_out[6];
   endproperty
   a_pop: assert property (p_pop) else $error("not empty");
   property p_flush;
      s_flush ##1 req_in.addr == TRF_QUEUE_ADDR |-> rdata_out == 8'h40;
   endproperty
   a_flush: assert property (p_flush) else $error("flush");
   property p_empty;
      q_rd && rdata_out[6] |-> !rdata_out[7] && rdata_out[4:0] == 5'h0;
   endproperty
   a_empty: assert property (p_empty) else $error("empty byte");
   property p_code;
      f_sel |-> rdata_out[7:2] == 6'h0 && rdata_out[1:0] != 2'b11;
   endproperty
   a_code: assert property (p_code) else $error("fault code");
   property p_stop;
      f_sel && rdata_out[1:0] != 2'h0 |-> !scan_allow_out;
   endproperty
   a_stop: assert property (p_stop) else $error("scan on fault");
   property p_hold;
      req_in.wr && f_sel && config_in[TRF_RUN_BIT] && rdata_out[1:0] != 2'h0
         ##1 f_sel |-> rdata_out == $past(rdata_out);
   endproperty
   a_hold: assert property (p_hold) else $error("fault cleared");
   property p_en;
      $rose(irq_n_oe_out) |-> $past(config_in[TRF_IRQ_EN_BIT]);
   endproperty
   a_en: assert property (p_en) else $error("irq disabled");
   property p_pin;
      irq_n_out == 1'b0;
   endproperty
   a_pin: assert property (p_pin) else $error("pin level");
endmodule
bind trf_report trf_report_properties i_props (
   .clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(req_in),
   .rdata_out(rdata_out), .config_in(config_in),
   .master_period_setting_in(master_period_setting_in),
   .duty_cycled_run_mode_in(duty_cycled_run_mode_in),
   .touch_active_flag_in(touch_active_flag_in),
   .live_position_in(live_position_in), .event_valid_in(event_valid_in),
   .event_in(event_in), .short_gnd_in(short_gnd_in),
   .short_sup_in(short_sup_in), .scan_allow_out(scan_allow_out),
   .irq_n_out(irq_n_out), .irq_n_oe_out(irq_n_oe_out));

// ---- tb/trf_host.sv ----
// host model: one register access per clock on the decoded port
// assumes rdata_in is combinational and valid in the request cycle
`timescale 1ns/1ps
module trf_host
   import trf_pkg::*;
(
   // clock
   input  wire logic       clk_in,
   // register port
   input  wire logic [7:0] rdata_in,
   output trf_req_s        req_out
);
   initial req_out = '0;
   // the request stays up between calls so bursts run back to back
   task automatic access(input logic [7:0] a, input logic [7:0] wd,
                         input logic wr, output logic [7:0] rd);
      @(negedge clk_in);
      req_out <= '{addr: a, wdata: wd, rd: !wr, wr: wr};
      @(posedge clk_in);
      rd = rdata_in;
   endtask
   task automatic idle();
      @(negedge clk_in);
      req_out <= '0;
   endtask
endmodule

// ---- tb/trf_report_tb_top.sv ----
// self-checking bench for trf_report against a queue model
// assumes the host model in trf_host and a 40 MHz clock
`timescale 1ns/1ps
module trf_report_tb_top
   import trf_pkg::*;
;
   logic       clk_in = 1'b0;
   logic       reset_n_in = 1'b0;
   trf_req_s   req;
   trf_event_s ev = '0;
   logic [7:0] rdata, d;
   logic [7:0] cfg = 8'h00;
   logic       ev_valid = 1'b0, touch = 1'b0, sgnd = 1'b0, ssup = 1'b0;
   logic       scan_ok, irq_n, irq_oe;
   logic [3:0] livepos = 4'h0;
   int         q[$];
   bit         ovf;
   int         num_errors = 0;
   int         cmp_count = 0;
   always #12.5 clk_in = ~clk_in;
   trf_report i_dut (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(req),
      .rdata_out(rdata), .config_in(cfg),
      .master_period_setting_in(8'h00), .duty_cycled_run_mode_in(1'b0),
      .touch_active_flag_in(touch), .live_position_in(livepos),
      .event_valid_in(ev_valid), .event_in(ev), .short_gnd_in(sgnd),
      .short_sup_in(ssup), .scan_allow_out(scan_ok), .irq_n_out(irq_n),
      .irq_n_oe_out(irq_oe));
   trf_host i_host (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      i_host.access(a, 8'h00, 1'b0, d);
   endtask
   task automatic rd_q();
      logic [7:0] e;
      e = (q.size() == 0) ? {2'b01, ovf, 5'h0}
                          : {q.size() > 1, 1'b0, ovf, 5'(q[0])};
      rd(TRF_QUEUE_ADDR);
      chk(d, e);
      if (q.size() > 0) void'(q.pop_front());
      if (q.size() == 0) ovf = 1'b0;
   endtask
   task automatic flush();
      i_host.access(TRF_QUEUE_ADDR, 8'h00, 1'b1, d);
      q.delete();
      ovf = 1'b0;
   endtask
   // events stream one per clock; the model drops what the 30-entry queue cannot hold
   task automatic push_n(input int n);
      logic [4:0] v;
      for (int i = 0; i < n; i++) begin
         @(negedge clk_in);
         v = {1'($urandom), 4'($urandom_range(7))};
         ev_valid <= 1'b1;
         ev <= v;
         if (q.size() < TRF_QUEUE_DEPTH) q.push_back(v);
         else ovf = 1'b1;
      end
      @(negedge clk_in);
      ev_valid <= 1'b0;
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_in);
      num_errors++;
      close_out();
   end
   initial begin
      void'($urandom(59));
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      reset_n_in <= 1'b1;
      rd_q();
      rd(TRF_FAULT_ADDR);
      chk(d, 8'h00);
      rd(8'h05);
      chk(d, 8'h00);
      i_host.access(TRF_LIVE_ADDR, 8'hff, 1'b1, d);
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_in);
         touch <= 1'($urandom);
         livepos <= 4'($urandom_range(7));
         rd(TRF_LIVE_ADDR);
         chk(d, {3'h0, touch, livepos});
      end
      i_host.idle();
      cfg <= 8'h01;
      push_n(2);
      repeat (4) @(negedge clk_in);
      chk({7'h0, irq_oe}, 8'h00);
      flush();
      rd_q();
      i_host.idle();
      cfg <= 8'h03;
      push_n(3);
      repeat (3) @(negedge clk_in);
      chk({6'h0, irq_oe, irq_n}, 8'h02);
      rd_q();
      i_host.idle();
      repeat (2) @(negedge clk_in);
      chk({7'h0, irq_oe}, 8'h00);
      repeat (3) rd_q();
      i_host.idle();
      // new data arrives well inside the spacing of the last interrupt
      push_n(32);
      chk({7'h0, irq_oe}, 8'h00);
      repeat (31) rd_q();
      i_host.idle();
      push_n(31);
      flush();
      rd_q();
      i_host.idle();
      sgnd <= 1'b1;
      ssup <= 1'b1;
      repeat (3) @(negedge clk_in);
      rd(TRF_FAULT_ADDR);
      chk({d[6:0], scan_ok}, 8'h02);
      i_host.access(TRF_FAULT_ADDR, 8'h00, 1'b1, d);
      rd(TRF_FAULT_ADDR);
      chk(d, 8'h01);
      i_host.idle();
      cfg <= 8'h00;
      sgnd <= 1'b0;
      ssup <= 1'b0;
      i_host.access(TRF_FAULT_ADDR, 8'h00, 1'b1, d);
      rd(TRF_FAULT_ADDR);
      chk(d, 8'h00);
      i_host.idle();
      cfg <= 8'h01;
      repeat (2) @(negedge clk_in);
      chk({7'h0, scan_ok}, 8'h01);
      ssup <= 1'b1;
      repeat (3) @(negedge clk_in);
      rd(TRF_FAULT_ADDR);
      chk({d[6:0], scan_ok}, 8'h04);
      close_out();
   end
endmodule
